// ### logic/ram_decoder_pkg.sv
package ram_decoder_pkg;

	// address map
	localparam logic [31:0] MAIN_BASE   = 32'h2000_0000;
	localparam logic [31:0] MAIN_BYTES  = 32'h0001_4000;
	localparam logic [31:0] PAR_BYTES   = 32'h0000_8000;
	localparam logic [31:0] RET_BASE    = 32'h2001_4000;
	localparam logic [31:0] RET_BYTES   = 32'h0000_4000;
	localparam logic [31:0] CCM_BASE    = 32'h1000_0000;
	localparam logic [31:0] CCM_ALIAS   = 32'h2001_8000;
	localparam logic [31:0] CCM_BYTES   = 32'h0000_4000;
	localparam logic [31:0] REMAP_BASE  = 32'h0000_0000;

	// array depths in 32-bit words
	localparam int MAIN_WORDS = 20480;
	localparam int RET_WORDS  = 4096;
	localparam int CCM_WORDS  = 4096;
	localparam int PAR_WORDS  = 8192;

	// field positions inside a region offset
	localparam int WORD_LSB = 2;
	localparam int PAGE_LSB = 10;
	localparam int PAGE_MSB = 13;

	// wait states, extra cycles beyond the one-cycle latency from request to read data
	localparam int WAIT_STATES = 0;

	typedef enum logic [1:0] {
		REG_NONE = 2'b00,
		REG_MAIN = 2'b01,
		REG_RET  = 2'b10,
		REG_CCM  = 2'b11
	} region_t;

	typedef struct packed {
		logic        rvalid;
		logic        err;
		logic        chk;
		logic [3:0]  par;
		logic [31:0] rdata;
	} port_t;

	typedef struct packed {
		port_t [1:0] pt;
		logic        par_err;
	} state_t;

endpackage : ram_decoder_pkg

// ### logic/byte_parity_check.sv
`timescale 1ns/1ps
// compares the even parity of one byte against its stored bit
module byte_parity_check (
	input  wire logic [7:0] data,
	input  wire logic       stored,
	output logic            mismatch
);
	assign mismatch = (^data) != stored;
endmodule : byte_parity_check

// ### logic/multi_region_ram_decoder.sv
`timescale 1ns/1ps
// Overview of operation
// - decode 80 KB main RAM at 0x2000_0000 on the system bus
// - main RAM also on code bus when booting from it or remapped
// - parity covers only the lowest 32 KB of main RAM
// - decode 16 KB retained RAM at 0x2001_4000 on the system bus
// - retained RAM keeps its contents through reset
// - decode 16 KB core-coupled RAM at 0x1000_0000 on the code bus
// - core-coupled RAM aliased at 0x2001_8000 on the system bus
// - core-coupled RAM has parity and per-1KB-page write protection
// - every region answers with zero wait states, except the system bus waits a cycle when the code bus hits the same region
// - parity error is an output usable as timer break source
module multi_region_ram_decoder
	import ram_decoder_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        code_req,
	input  wire logic        code_we,
	input  wire logic [31:0] code_addr,
	input  wire logic [3:0]  code_be,
	input  wire logic [31:0] code_wdata,
	output logic             code_ready,
	output logic             code_rvalid,
	output logic [31:0]      code_rdata,
	output logic             code_err,
	input  wire logic        sys_req,
	input  wire logic        sys_we,
	input  wire logic [31:0] sys_addr,
	input  wire logic [3:0]  sys_be,
	input  wire logic [31:0] sys_wdata,
	output logic             sys_ready,
	output logic             sys_rvalid,
	output logic [31:0]      sys_rdata,
	output logic             sys_err,
	input  wire logic        boot_from_main_ram,
	input  wire logic        memory_remap_select,
	input  wire logic [15:0] ccm_write_protect,
	input  wire logic        parity_error_clear,
	output logic             parity_error,
	output logic             parity_break
);

	logic [31:0] main_ram [MAIN_WORDS];
	logic [31:0] ret_ram  [RET_WORDS];
	logic [31:0] ccm_ram  [CCM_WORDS];
	logic [3:0]  main_par [PAR_WORDS];
	logic [3:0]  ccm_par  [CCM_WORDS];

	state_t      q;
	state_t      d;
	region_t     rg     [2];
	logic [31:0] off    [2];
	logic [31:0] addr   [2];
	logic [31:0] wd     [2];
	logic [3:0]  be     [2];
	logic [1:0]  req;
	logic [1:0]  we;
	logic [1:0]  go;
	logic [1:0]  wp_hit;
	logic [1:0]  par_cov;
	logic [3:0]  mm     [2];
	logic        remap_en;
	logic        parity_fault;

	// region decode; code bus sees core-coupled RAM and optionally main RAM
	function automatic region_t decode(input logic [31:0] a, input logic code_bus,
		input logic remap);
		region_t r;
		r = REG_NONE;
		if (code_bus) begin
			if (a >= CCM_BASE && a < CCM_BASE + CCM_BYTES)
				r = REG_CCM;
			else if (remap && a >= REMAP_BASE && a < REMAP_BASE + MAIN_BYTES)
				r = REG_MAIN;
		end else begin
			if (a >= MAIN_BASE && a < MAIN_BASE + MAIN_BYTES)
				r = REG_MAIN;
			else if (a >= RET_BASE && a < RET_BASE + RET_BYTES)
				r = REG_RET;
			else if (a >= CCM_ALIAS && a < CCM_ALIAS + CCM_BYTES)
				r = REG_CCM;
		end
		return r;
	endfunction : decode

	// byte offset inside the decoded region
	function automatic logic [31:0] region_off(input logic [31:0] a, input region_t r,
		input logic code_bus);
		logic [31:0] o;
		o = 32'h0000_0000;
		unique case (r)
			REG_MAIN: o = a - (code_bus ? REMAP_BASE : MAIN_BASE);
			REG_RET:  o = a - RET_BASE;
			REG_CCM:  o = a - (code_bus ? CCM_BASE : CCM_ALIAS);
			REG_NONE: o = 32'h0000_0000;
		endcase
		return o;
	endfunction : region_off

	// port 0 is the code bus, port 1 the shared system bus
	assign req      = {sys_req, code_req};
	assign we       = {sys_we, code_we};
	assign addr[0]  = code_addr;
	assign addr[1]  = sys_addr;
	assign wd[0]    = code_wdata;
	assign wd[1]    = sys_wdata;
	assign be[0]    = code_be;
	assign be[1]    = sys_be;
	assign remap_en = boot_from_main_ram | memory_remap_select;

	// decode, protection and parity coverage per port
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			rg[p]  = req[p] ? decode(addr[p], p == 0, remap_en) : REG_NONE;
			off[p] = region_off(addr[p], rg[p], p == 0);
			wp_hit[p] = we[p] && rg[p] == REG_CCM &&
				ccm_write_protect[off[p][PAGE_MSB:PAGE_LSB]];
			par_cov[p] = (rg[p] == REG_MAIN && off[p] < PAR_BYTES) || rg[p] == REG_CCM;
		end
	end

	// the code bus owns a bank it hits; the system bus waits that cycle
	assign code_ready = 1'b1;
	assign sys_ready  = !(rg[0] != REG_NONE && rg[0] == decode(sys_addr, 1'b0, remap_en));
	assign go         = {sys_req & sys_ready, code_req};

	// array write port, arrays have no reset so contents are retained
	always_ff @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			if (go[p] && we[p] && !wp_hit[p]) begin
				for (int b = 0; b < 4; b++) begin
					if (be[p][b]) begin
						unique case (rg[p])
							REG_MAIN: begin
								main_ram[off[p][16:2]][b*8+:8] <= wd[p][b*8+:8];
								if (par_cov[p])
									main_par[off[p][14:2]][b] <= ^wd[p][b*8+:8];
							end
							REG_RET: ret_ram[off[p][13:2]][b*8+:8] <= wd[p][b*8+:8];
							REG_CCM: begin
								ccm_ram[off[p][13:2]][b*8+:8] <= wd[p][b*8+:8];
								ccm_par[off[p][13:2]][b]      <= ^wd[p][b*8+:8];
							end
							REG_NONE: ;
						endcase
					end
				end
			end
		end
	end

	// next state: read data, answers and sticky parity flag
	always_comb begin
		d = q;
		for (int p = 0; p < 2; p++) begin
			// answer in the cycle after the request
			d.pt[p].rvalid = go[p] && !we[p] && rg[p] != REG_NONE;
			// error on unmapped or protected write
			d.pt[p].err    = go[p] && (rg[p] == REG_NONE || wp_hit[p]);
			d.pt[p].chk    = d.pt[p].rvalid && par_cov[p];
			d.pt[p].rdata  = 32'h0000_0000;
			d.pt[p].par    = 4'h0;
			if (d.pt[p].rvalid) begin
				unique case (rg[p])
					REG_MAIN: begin
						d.pt[p].rdata = main_ram[off[p][16:2]];
						if (par_cov[p])
							d.pt[p].par = main_par[off[p][14:2]];
					end
					REG_RET: d.pt[p].rdata = ret_ram[off[p][13:2]];
					REG_CCM: begin
						d.pt[p].rdata = ccm_ram[off[p][13:2]];
						d.pt[p].par   = ccm_par[off[p][13:2]];
					end
					REG_NONE: ;
				endcase
			end
		end
		// sticky flag, a new fault wins over the clear
		d.par_err = parity_fault | (q.par_err & ~parity_error_clear);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			q <= '0;
		else
			q <= d;
	end

	// per byte check of the returned word
	for (genvar p = 0; p < 2; p++) begin : g_port
		for (genvar b = 0; b < 4; b++) begin : g_byte
			byte_parity_check u_chk (
				.data     (q.pt[p].rdata[b*8+:8]),
				.stored   (q.pt[p].par[b]),
				.mismatch (mm[p][b])
			);
		end
	end

	assign parity_fault = (q.pt[0].chk & (|mm[0])) | (q.pt[1].chk & (|mm[1]));

	// outputs
	assign code_rvalid  = q.pt[0].rvalid;
	assign code_rdata   = q.pt[0].rdata;
	assign code_err     = q.pt[0].err;
	assign sys_rvalid   = q.pt[1].rvalid;
	assign sys_rdata    = q.pt[1].rdata;
	assign sys_err      = q.pt[1].err;
	assign parity_error = q.par_err;
	assign parity_break = q.par_err;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_sys_read;
		go[1] && !sys_we && rg[1] != REG_NONE;
	endsequence

	sequence s_code_read;
		code_req && !code_we && rg[0] != REG_NONE;
	endsequence

	sys_read_answer_a: assert property (s_sys_read |=> sys_rvalid && !sys_err)
		else $error("system bus read not answered next cycle");
	code_read_answer_a: assert property (s_code_read |=> code_rvalid ##1 (!code_rvalid || $past(code_req)))
		else $error("code bus read not answered next cycle");
	main_decode_a: assert property (sys_req && sys_addr >= MAIN_BASE && sys_addr < MAIN_BASE + MAIN_BYTES |-> rg[1] == REG_MAIN)
		else $error("main region not decoded");
	code_remap_a: assert property (code_req && !remap_en && code_addr < MAIN_BYTES |=> !code_rvalid && code_err)
		else $error("main region visible on code bus without remap");
	retained_decode_a: assert property (sys_req && sys_addr >= RET_BASE && sys_addr < RET_BASE + RET_BYTES |-> rg[1] == REG_RET)
		else $error("retained region not decoded");
	ccm_alias_a: assert property (sys_req && sys_addr >= CCM_ALIAS && sys_addr < CCM_ALIAS + CCM_BYTES |-> rg[1] == REG_CCM)
		else $error("core-coupled alias not decoded");
	ccm_code_a: assert property (code_req && code_addr >= CCM_BASE && code_addr < CCM_BASE + CCM_BYTES |-> rg[0] == REG_CCM)
		else $error("core-coupled region not decoded on code bus");
	parity_range_a: assert property (s_sys_read and (rg[1] == REG_RET || off[1] >= PAR_BYTES && rg[1] == REG_MAIN) |=> !q.pt[1].chk)
		else $error("parity checked outside covered range");
	protect_err_a: assert property (go[1] && wp_hit[1] |=> sys_err && !sys_rvalid)
		else $error("protected page write not flagged");
	parity_sticky_a: assert property (parity_fault |=> parity_error && parity_break)
		else $error("parity fault not latched");
	parity_hold_a: assert property (parity_error && !parity_error_clear |=> parity_error)
		else $error("parity flag dropped without clear");
	parity_rise_a: assert property ($rose(parity_error) |-> $past(parity_fault))
		else $error("parity flag rose without a fault");

endmodule : multi_region_ram_decoder

// ### testbench/bus_master.sv
`timescale 1ns/1ps
// bus master model: one request at a time, driven at the falling edge
module bus_master (
	input  wire logic        clk,
	input  wire logic        ready,
	input  wire logic        rvalid,
	input  wire logic [31:0] rdata,
	input  wire logic        err,
	output logic             req,
	output logic             we,
	output logic [31:0]      addr,
	output logic [3:0]       be,
	output logic [31:0]      wdata
);
	// idle bus at time zero
	initial begin
		req = 1'b0;
		we = 1'b0;
		addr = 32'h0;
		be = 4'h0;
		wdata = 32'h0;
	end

	// one access: hold until taken, collect the answer one cycle later
	task automatic access(input logic w, input logic [31:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] rd, output logic er, output logic rv);
		@(negedge clk);
		req = 1'b1;
		we = w;
		addr = a;
		be = b;
		wdata = d;
		do @(posedge clk); while (ready !== 1'b1);
		@(negedge clk);
		rd = rdata;
		er = err;
		rv = rvalid;
		req = 1'b0;
		// released lines no longer show the last value
		addr = ~addr;
		wdata = ~wdata;
	endtask : access
endmodule : bus_master

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
	logic        clk, resetn, boot_from_main_ram, memory_remap_select, parity_error_clear;
	logic        code_req, code_we, code_ready, code_rvalid, code_err;
	logic        sys_req, sys_we, sys_ready, sys_rvalid, sys_err, parity_error, parity_break;
	logic [31:0] code_addr, code_wdata, code_rdata, sys_addr, sys_wdata, sys_rdata, rd, rd2;
	logic [3:0]  code_be, sys_be;
	logic [15:0] ccm_write_protect;
	logic        er, rv, er2, rv2;
	int          bad_count = 0;
	int          checks_done = 0;
	typedef struct packed {
		logic        cb;
		logic        we;
		logic [31:0] a;
		logic [3:0]  be;
		logic [31:0] d;
		logic        er;
	} row_t;
	// bus, write, address, enables, data written or expected, error expected
	row_t rows [14] = '{
		'{1'b0, 1'b1, 32'h2000_0000, 4'hF, 32'hA5A5_1234, 1'b0},
		'{1'b0, 1'b1, 32'h2000_0000, 4'h1, 32'h0000_00FF, 1'b0},
		'{1'b0, 1'b0, 32'h2000_0000, 4'hF, 32'hA5A5_12FF, 1'b0},
		'{1'b0, 1'b1, 32'h2001_3FFC, 4'hF, 32'h1357_9BDF, 1'b0},
		'{1'b0, 1'b0, 32'h2001_3FFC, 4'hF, 32'h1357_9BDF, 1'b0},
		'{1'b0, 1'b1, 32'h2001_4000, 4'hF, 32'h2468_ACE0, 1'b0},
		'{1'b0, 1'b0, 32'h2001_4000, 4'hF, 32'h2468_ACE0, 1'b0},
		'{1'b0, 1'b1, 32'h2001_8400, 4'hF, 32'hCAFE_0001, 1'b0},
		'{1'b1, 1'b0, 32'h1000_0400, 4'hF, 32'hCAFE_0001, 1'b0},
		'{1'b1, 1'b1, 32'h1000_3FFC, 4'hF, 32'h8765_4321, 1'b0},
		'{1'b0, 1'b0, 32'h2001_BFFC, 4'hF, 32'h8765_4321, 1'b0},
		'{1'b0, 1'b0, 32'h2001_C000, 4'hF, 32'h0000_0000, 1'b1},
		'{1'b1, 1'b0, 32'h0000_0000, 4'hF, 32'h0000_0000, 1'b1},
		'{1'b0, 1'b1, 32'h1FFF_FFFC, 4'hF, 32'hFFFF_0000, 1'b1}
	};

	multi_region_ram_decoder u_dut (.clk(clk), .resetn(resetn),
		.code_req(code_req), .code_we(code_we), .code_addr(code_addr), .code_be(code_be),
		.code_wdata(code_wdata), .code_ready(code_ready), .code_rvalid(code_rvalid),
		.code_rdata(code_rdata), .code_err(code_err), .sys_req(sys_req), .sys_we(sys_we),
		.sys_addr(sys_addr), .sys_be(sys_be), .sys_wdata(sys_wdata), .sys_ready(sys_ready),
		.sys_rvalid(sys_rvalid), .sys_rdata(sys_rdata), .sys_err(sys_err),
		.boot_from_main_ram(boot_from_main_ram), .memory_remap_select(memory_remap_select),
		.ccm_write_protect(ccm_write_protect), .parity_error_clear(parity_error_clear),
		.parity_error(parity_error), .parity_break(parity_break));
	bus_master u_code (.clk(clk), .ready(code_ready), .rvalid(code_rvalid), .rdata(code_rdata),
		.err(code_err), .req(code_req), .we(code_we), .addr(code_addr), .be(code_be),
		.wdata(code_wdata));
	bus_master u_sys (.clk(clk), .ready(sys_ready), .rvalid(sys_rvalid), .rdata(sys_rdata),
		.err(sys_err), .req(sys_req), .we(sys_we), .addr(sys_addr), .be(sys_be),
		.wdata(sys_wdata));

	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#(50 * 4000);
		bad_count++;
		complete_run();
	end

	task automatic complete_run;
		if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task automatic acc(input logic cb, input logic w, input logic [31:0] a,
		input logic [3:0] b, input logic [31:0] d);
		if (cb) u_code.access(w, a, b, d, rd, er, rv);
		else u_sys.access(w, a, b, d, rd, er, rv);
	endtask : acc

	task automatic do_reset;
		resetn = 1'b0;
		repeat (6) @(negedge clk);
		`CHK("code_ready", 1'b1, code_ready)
		`CHK("sys_rvalid", 1'b0, sys_rvalid)
		`CHK("parity_error", 1'b0, parity_error)
		resetn = 1'b1;
	endtask : do_reset

	// table first, then the awkward cases
	initial begin
		boot_from_main_ram = 1'b0;
		memory_remap_select = 1'b0;
		parity_error_clear = 1'b0;
		ccm_write_protect = 16'h0000;
		do_reset();
		for (int i = 0; i < 14; i++) begin
			acc(rows[i].cb, rows[i].we, rows[i].a, rows[i].be, rows[i].d);
			`CHK("err", rows[i].er, er)
			`CHK("rvalid", ~rows[i].we & ~rows[i].er, rv)
			if (!rows[i].we) `CHK("rdata", rows[i].d, rd)
		end
		boot_from_main_ram = 1'b1;
		acc(1'b1, 1'b0, 32'h0000_0000, 4'hF, 32'h0);
		`CHK("boot rdata", 32'hA5A5_12FF, rd)
		`CHK("boot err", 1'b0, er)
		boot_from_main_ram = 1'b0;
		memory_remap_select = 1'b1;
		acc(1'b1, 1'b0, 32'h0000_0000, 4'hF, 32'h0);
		`CHK("remap rdata", 32'hA5A5_12FF, rd)
		`CHK("remap rvalid", 1'b1, rv)
		memory_remap_select = 1'b0;
		ccm_write_protect = 16'h0002;
		acc(1'b0, 1'b1, 32'h2001_8400, 4'hF, 32'hFFFF_FFFF);
		`CHK("prot err", 1'b1, er)
		acc(1'b0, 1'b1, 32'h2001_8000, 4'hF, 32'h1111_2222);
		`CHK("page0 err", 1'b0, er)
		acc(1'b0, 1'b0, 32'h2001_8400, 4'hF, 32'h0);
		`CHK("prot rdata", 32'hCAFE_0001, rd)
		acc(1'b0, 1'b0, 32'h2000_8000, 4'hF, 32'h0);
		@(negedge clk);
		`CHK("no parity", 1'b0, parity_error)
		`CHK("break", 1'b0, parity_break)
		// clear pulse on a quiet flag leaves it low
		parity_error_clear = 1'b1;
		@(negedge clk);
		parity_error_clear = 1'b0;
		`CHK("cleared", 1'b0, parity_error)
		// both buses on the core-coupled block in the same cycle
		fork
			u_code.access(1'b0, 32'h1000_0400, 4'hF, 32'h0, rd2, er2, rv2);
			u_sys.access(1'b0, 32'h2001_8000, 4'hF, 32'h0, rd, er, rv);
			begin
				@(negedge clk);
				#1;
				`CHK("sys_ready", 1'b0, sys_ready)
			end
		join
		`CHK("code rdata", 32'hCAFE_0001, rd2)
		`CHK("sys rdata", 32'h1111_2222, rd)
		do_reset();
		acc(1'b0, 1'b0, 32'h2001_4000, 4'hF, 32'h0);
		`CHK("kept", 32'h2468_ACE0, rd)
		complete_run();
	end
endmodule : tb_top
